// file: pfc_params.svh
// Constants of the packet format configuration block.
// Assumes inclusion by the package and the design module only.
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH
`define PFC_CFG_ADDR 8'h04
`define PFC_CFG_RESET 8'h00
`define PFC_EXT_LSB 6
`define PFC_LENORD_BIT 5
`define PFC_DATORD_BIT 4
`define PFC_AUTODET_BIT 3
`define PFC_RSVD_BIT 2
`define PFC_FMT_LSB 0
`define PFC_CI_EXT2 8'h8c
`define PFC_CI_EXT8 8'h8d
`define PFC_EXT2_BYTES 4'h2
`define PFC_EXT8_BYTES 4'h8
`define PFC_BIT_LAST 3'h7
`endif

// file: pfc_pkg.sv
// Types of the packet format configuration block.
// Assumes pfc_params.svh sits in the include path.
`include "pfc_params.svh"
package pfc_pkg;
  typedef enum logic [1:0] {
    PFC_FMT_A = 2'b00,
    PFC_FMT_B = 2'b01,
    PFC_FMT_C = 2'b10,
    PFC_FMT_RSVD = 2'b11
  } pfc_fmt_t;
  typedef enum logic [1:0] {
    PFC_EXT_NONE = 2'b00,
    PFC_EXT_TWO = 2'b01,
    PFC_EXT_EIGHT = 2'b10,
    PFC_EXT_RSVD = 2'b11
  } pfc_ext_t;
  // Decoded settings handed to the framer
  typedef struct packed {
    pfc_fmt_t frame_format_select;
    pfc_ext_t link_ext_select;
    logic length_field_bit_order;
    logic payload_bit_order;
    logic rx_ext_autodetect_off;
  } pfc_cfg_t;
endpackage

// file: pfc_packet_config.sv
// Packet configuration register and the bit-order / extension decode it steers.
// Assumes a host register port (addr, write strobe, data) on clk_i, and a
// framer that moves one byte at a time, marking length bytes apart from data.
`timescale 1ns/100ps
`include "pfc_params.svh"
module pfc_packet_config
  import pfc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic byte_valid_i,
  input wire logic byte_is_len_i,
  input wire logic [7:0] byte_i,
  input wire logic [7:0] rx_ci_i,
  input wire logic rx_ci_valid_i,
  output logic [7:0] reg_rdata_o,
  output pfc_cfg_t cfg_o,
  output logic [7:0] ext_ci_o,
  output logic [3:0] ext_len_o,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic rx_ext_found_o,
  output logic [3:0] rx_ext_len_o
);

  logic [7:0] cfg_ff;
  logic [7:0] nxt_cfg;
  logic hit;
  pfc_ext_t ext_sel;
  logic ord_lsb;
  logic [7:0] reordered;

  assign hit = (reg_addr_i == `PFC_CFG_ADDR);
  assign ext_sel = pfc_ext_t'(cfg_ff[`PFC_EXT_LSB +: 2]);
  assign nxt_cfg = reg_wdata_i;

  // Configuration register; all bits, reserved bit 2 included, are read/write
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      cfg_ff <= `PFC_CFG_RESET;
    else if (reg_wr_i && hit)
      cfg_ff <= nxt_cfg;
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= hit ? cfg_ff : 8'h00;
  end

  // Decoded fields registered so the framer sees flop outputs
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      cfg_o <= '0;
    else
    begin
      cfg_o.frame_format_select <= pfc_fmt_t'(cfg_ff[`PFC_FMT_LSB +: 2]);
      cfg_o.link_ext_select <= ext_sel;
      cfg_o.length_field_bit_order <= cfg_ff[`PFC_LENORD_BIT];
      cfg_o.payload_bit_order <= cfg_ff[`PFC_DATORD_BIT];
      cfg_o.rx_ext_autodetect_off <= cfg_ff[`PFC_AUTODET_BIT];
    end
  end

  // Extension CI and length; reserved code behaves as no extension
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ext_ci_o <= 8'h00;
      ext_len_o <= 4'h0;
    end
    else
    begin
      unique case (ext_sel)
        PFC_EXT_TWO:
        begin
          ext_ci_o <= `PFC_CI_EXT2;
          ext_len_o <= `PFC_EXT2_BYTES;
        end
        PFC_EXT_EIGHT:
        begin
          ext_ci_o <= `PFC_CI_EXT8;
          ext_len_o <= `PFC_EXT8_BYTES;
        end
        PFC_EXT_NONE, PFC_EXT_RSVD:
        begin
          ext_ci_o <= 8'h00;
          ext_len_o <= 4'h0;
        end
      endcase
    end
  end

  // Bit order: one reversal serves transmit bytes only; rx_ci_i is not reordered
  assign ord_lsb = byte_is_len_i ? cfg_ff[`PFC_LENORD_BIT]
                                 : cfg_ff[`PFC_DATORD_BIT];
  always_comb
  begin
    reordered = byte_i;
    if (ord_lsb)
      for (int i = 0; i <= `PFC_BIT_LAST; i++)
        reordered[i] = byte_i[`PFC_BIT_LAST - i];
  end

  // Byte stage toward the serialiser; bit 7 of byte_o goes on air first
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      byte_valid_o <= 1'b0;
      byte_o <= 8'h00;
    end
    else
    begin
      byte_valid_o <= byte_valid_i;
      if (byte_valid_i)
        byte_o <= reordered;
    end
  end

  // Receive autodetect; limited to the 2/8-byte CI codes handled here
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rx_ext_found_o <= 1'b0;
      rx_ext_len_o <= 4'h0;
    end
    else if (rx_ci_valid_i)
    begin
      rx_ext_found_o <= 1'b0;
      rx_ext_len_o <= 4'h0;
      if (!cfg_ff[`PFC_AUTODET_BIT])
      begin
        if (rx_ci_i == `PFC_CI_EXT2)
        begin
          rx_ext_found_o <= 1'b1;
          rx_ext_len_o <= `PFC_EXT2_BYTES;
        end
        else if (rx_ci_i == `PFC_CI_EXT8)
        begin
          rx_ext_found_o <= 1'b1;
          rx_ext_len_o <= `PFC_EXT8_BYTES;
        end
      end
    end
  end

  // Independent bit reversal for the order checks, so a broken datapath loop cannot hide
  function automatic logic [7:0] flip_bits(input logic [7:0] x);
    flip_bits = {x[0], x[1], x[2], x[3], x[4], x[5], x[6], x[7]};
  endfunction

  // A host write that lands in the configuration register
  sequence s_cfg_write;
    reg_wr_i && hit;
  endsequence

  a_reset_zero: assert property (@(posedge clk_i)
    sys_rst_i |=> cfg_ff == `PFC_CFG_RESET)
    else $error("config not zero after reset");

  a_write_store: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_cfg_write |=> cfg_ff == $past(reg_wdata_i))
    else $error("config write lost");

  a_ext_none: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ext_sel == PFC_EXT_NONE |=> ext_len_o == 4'h0)
    else $error("extension present when none selected");

  a_ext_two: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ext_sel == PFC_EXT_TWO |=> ext_ci_o == `PFC_CI_EXT2 && ext_len_o == `PFC_EXT2_BYTES)
    else $error("2-byte extension wrong");

  a_ext_eight: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ext_sel == PFC_EXT_EIGHT |=> ext_ci_o == `PFC_CI_EXT8 && ext_len_o == `PFC_EXT8_BYTES)
    else $error("8-byte extension wrong");

  a_len_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    byte_valid_i && byte_is_len_i |=>
      byte_o == ($past(cfg_ff[`PFC_LENORD_BIT]) ? flip_bits($past(byte_i)) : $past(byte_i)))
    else $error("length bit order wrong");

  a_data_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    byte_valid_i && !byte_is_len_i |=>
      byte_o == ($past(cfg_ff[`PFC_DATORD_BIT]) ? flip_bits($past(byte_i)) : $past(byte_i)))
    else $error("data bit order wrong");

  a_byte_valid: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    byte_valid_i |=> byte_valid_o)
    else $error("byte valid not passed on");

  a_autodet_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_ci_valid_i && cfg_ff[`PFC_AUTODET_BIT] |=> !rx_ext_found_o)
    else $error("autodetect fired while off");

  a_autodet_on: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_ci_valid_i && !cfg_ff[`PFC_AUTODET_BIT] && rx_ci_i == `PFC_CI_EXT8
      |=> rx_ext_found_o && rx_ext_len_o == `PFC_EXT8_BYTES)
    else $error("8-byte extension not detected");

  a_autodet_two: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_ci_valid_i && !cfg_ff[`PFC_AUTODET_BIT] && rx_ci_i == `PFC_CI_EXT2
      |=> rx_ext_found_o && rx_ext_len_o == `PFC_EXT2_BYTES)
    else $error("2-byte extension not detected");

  a_fmt_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_cfg_write |=> ##1 cfg_o.frame_format_select == pfc_fmt_t'($past(reg_wdata_i[1:0], 2)))
    else $error("format select not applied");

endmodule

// file: pfc_host_model.sv
// Host model for the packet configuration port.
// Assumes the bench calls wr and rd from procedural code.
`timescale 1ns/100ps
module pfc_host_model (
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o
);
  // Idle bus from time zero; no length value is ever issued here
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end
  // Any extension code, the 8-byte one included, can be chosen through this port
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d; // Released data must not look valid
  endtask
  // Data is taken once the read edge has updated the register
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b0;
    q = reg_rdata_i;
  endtask
endmodule

// file: pfc_packet_config_bench.sv
// Self-checking bench for the packet configuration block.
// Assumes pfc_host_model drives the register port.
`timescale 1ns/100ps
module pfc_packet_config_bench;
  import pfc_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic bv = 1'b0, bl = 1'b0, cv = 1'b0, wr, rdq, bvo, fnd;
  logic [7:0] b = 8'h00, ci = 8'h00, a, d, rd, v, rdata, eci, byo;
  logic [3:0] elen, rlen;
  logic [7:0] exp_q[$];
  pfc_cfg_t cfg_o;
  integer failures = 0, n_checks = 0, seed = 32'hb273, i, j, e;
  always #2.5 clk_i = ~clk_i;
  pfc_host_model u_host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(a),
    .reg_wr_o(wr), .reg_wdata_o(d), .reg_rd_o(rdq));
  pfc_packet_config u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(a),
    .reg_wr_i(wr), .reg_wdata_i(d), .reg_rd_i(rdq), .byte_valid_i(bv),
    .byte_is_len_i(bl), .byte_i(b), .rx_ci_i(ci), .rx_ci_valid_i(cv),
    .reg_rdata_o(rdata), .cfg_o(cfg_o), .ext_ci_o(eci), .ext_len_o(elen),
    .byte_valid_o(bvo), .byte_o(byo), .rx_ext_found_o(fnd), .rx_ext_len_o(rlen));
  function automatic logic [7:0] rev(input logic [7:0] x);
    for (int k = 0; k < 8; k++)
      rev[k] = x[7-k];
  endfunction
  task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, exp, got);
    end
  endtask
  // One compare task per kind of result, all counted in one place
  task automatic chk_reg(input string n, input logic [7:0] exp, input logic [7:0] got);
    chk(n, exp, got);
  endtask
  task automatic chk_cfg(input string n, input logic [7:0] exp, input logic [7:0] got);
    chk(n, exp, got);
  endtask
  task automatic chk_byte(input string n, input logic [7:0] exp, input logic [7:0] got);
    chk(n, exp, got);
  endtask
  task automatic chk_det(input string n, input logic [7:0] exp, input logic [7:0] got);
    chk(n, exp, got);
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Settings reach the framer two cycles after the write
  task automatic wcfg(input logic [7:0] x);
    u_host.wr(8'h04, x);
    v = x;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // Main sequence: reset, register decode, byte order, receive detect
  initial
  begin
    repeat (5) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    u_host.rd(8'h04, rd);
    chk_reg("reset", 8'h00, rd);
    chk_cfg("cfg", 8'h00, {1'b0, cfg_o});
    $display("test reset done");
    for (i = 0; i < 16; i++)
    begin
      e = $random(seed);
      wcfg({i[3:2], e[3:0], i[1:0]});
      chk_cfg("cfg", {1'b0, v[1:0], v[7:6], v[5:3]}, {1'b0, cfg_o});
      chk_cfg("ci", v[7:6] == 2'b01 ? 8'h8c : v[7:6] == 2'b10 ? 8'h8d : 8'h00, eci);
      chk_cfg("elen", v[7:6] == 2'b01 ? 8'h02 : v[7:6] == 2'b10 ? 8'h08 : 8'h00, {4'h0, elen});
      u_host.wr(8'h05, ~v);
      u_host.rd(8'h05, rd);
      chk_reg("unmapped", 8'h00, rd);
      u_host.rd(8'h04, rd);
      chk_reg("rdback", v, rd);
    end
    $display("test decode done");
    for (i = 0; i < 4; i++)
    begin
      wcfg({2'b00, i[1:0], 4'h0});
      for (j = 0; j < 8; j++)
      begin
        b = 8'($random(seed));
        bl = j[0];
        bv = 1'b1;
        exp_q.push_back((bl ? v[5] : v[4]) ? rev(b) : b);
        @(posedge clk_i);
        #1;
        chk_byte("bvalid", 8'h01, {7'h00, bvo});
        chk_byte("byte", exp_q.pop_front(), byo);
      end
      bv = 1'b0;
      @(posedge clk_i);
      #1;
      chk_byte("bvalid", 8'h00, {7'h00, bvo});
    end
    $display("test order done");
    for (i = 0; i < 8; i++)
    begin
      wcfg({4'h0, i[0], 3'h0});
      ci = i[2:1] == 2'd0 ? 8'h8c : i[2:1] == 2'd1 ? 8'h8d : 8'($random(seed));
      cv = 1'b1;
      @(posedge clk_i);
      #1;
      cv = 1'b0;
      e = v[3] ? 0 : ci == 8'h8c ? 2 : ci == 8'h8d ? 8 : 0;
      chk_det("found", {7'h00, e != 0}, {7'h00, fnd});
      chk_det("rlen", 8'(e), {4'h0, rlen});
    end
    $display("test detect done");
    summarize();
  end
  // Watchdog well beyond the expected run of a few hundred cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    failures++;
    summarize();
  end
endmodule
